// ===== hdl/ext_bus_if.sv
/*
 * External bus interface: turns single core requests into bus cycles towards
 * asynchronous memories, two ISA-style peripherals and two memory chips with a
 * row/column command port, with 16 data lines and buffer steering.
 * Assumes the memory chips are initialised and refreshed by other logic, that
 * sys_clk is forwarded to the memory clock pin at the pad, and that all pin
 * inputs are already synchronous to sys_clk.
 */
// Notes on behaviour
// RQ1 - Read/write level low on writes, high on reads
// RQ2 - Output enable low only during bus reads
// RQ3 - Sixteen bidirectional non-multiplexed data lines
// RQ4 - Read data captured on rising clock edge
// RQ5 - Per-window programmable port width applied
// RQ6 - Unmatched address uses fixed default configuration
// RQ7 - All sixteen data lines driven on writes
// RQ8 - Byte address out, multiplexed row/column for memory
// RQ9 - Address lines 1-23 plus 25, reusable
// RQ10 - Sixteen-bit synchronous memory, 64 megabytes, no async
// RQ11 - Active-low row and column strobes
// RQ12 - Memory write enable low on writes only
// RQ13 - Two memory chip selects, second reusable
// RQ14 - Upper and lower byte mask outputs
// RQ15 - Active-high memory clock enable, bus clock
// RQ16 - Two async-memory chip selects, second reusable
// RQ17 - Two ISA peripherals with read/write strobes
// RQ18 - ISA ready low inserts wait states
// RQ19 - Two buffer enable outputs
// RQ20 - Transfer acknowledge ends cycle next edge
// RQ21 - Buffer enable only for regions behind it
`timescale 1ns/100ps
`default_nettype none

module ext_bus_if (
    // Clock and reset
    input  wire logic                                                     sys_clk,
    input  wire logic                                                     nrst,
    // Core request
    input  wire logic                                                     req_valid,
    input  wire logic                                                     req_write,
    input  wire logic [1:0]                                               req_size,
    input  wire logic [25:0]                                              req_addr,
    input  wire logic [31:0]                                              req_wdata,
    output logic                                                          req_ready,
    // Core answer
    output logic                                                          rsp_done,
    output logic      [31:0]                                              rsp_rdata,
    // Window settings
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0]                          region_enable,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][ebi_pkg::DECODE_BITS-1:0] region_base,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][ebi_pkg::DECODE_BITS-1:0] region_mask,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0]                          region_port16,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][3:0]                     region_waits,
    // Alternate pin use
    input  wire logic                                                     addr25_as_gpo,
    input  wire logic                                                     addr25_gpo_val,
    input  wire logic                                                     sdsel1_as_gpo,
    input  wire logic                                                     sdsel1_gpo_val,
    input  wire logic                                                     memsel1_as_gpo,
    input  wire logic                                                     memsel1_gpo_val,
    // Address and control
    output logic      [23:1]                                              bus_addr,
    output logic                                                          bus_addr25,
    output logic                                                          bus_read_write,
    output logic                                                          bus_output_en_n,
    input  wire logic                                                     transfer_ack_n,
    // Data lines D[31:16]
    input  wire logic [15:0]                                              data_in,
    output logic      [15:0]                                              data_out,
    output logic                                                          data_oe,
    // Memory command port
    output logic                                                          sdram_row_strobe_n,
    output logic                                                          sdram_col_strobe_n,
    output logic                                                          sdram_write_en_n,
    output logic                                                          sdram_select0_n,
    output logic                                                          sdram_select1_n,
    output logic                                                          sdram_upper_mask,
    output logic                                                          sdram_lower_mask,
    output logic                                                          sdram_clock_enable,
    // Asynchronous memory selects
    output logic                                                          mem_select0_n,
    output logic                                                          mem_select1_n,
    // ISA peripherals
    output logic                                                          isa0_read_strobe_n,
    output logic                                                          isa0_write_strobe_n,
    output logic                                                          isa1_read_strobe_n,
    output logic                                                          isa1_write_strobe_n,
    input  wire logic                                                     isa_io_ready,
    // Buffer steering
    output logic                                                          buffer_enable0,
    output logic                                                          buffer_enable1
);

    ebi_pkg::bus_regs_t s_r;
    ebi_pkg::bus_regs_t s_nxt;

    logic [2:0]  hit_idx;
    logic        hit_port16;
    logic [3:0]  hit_waits;
    logic        bb;
    logic        bb_req;
    logic        beat_end;
    logic [7:0]  lane8;
    logic [2:0]  nbytes;
    logic        sd_cur;
    logic        sd_nxt;
    logic        active;

    region_match u_match (
        .addr_hi    (req_addr[ebi_pkg::DECODE_LSB +: ebi_pkg::DECODE_BITS]),
        .enable     (region_enable),
        .base       (region_base),
        .mask       (region_mask),
        .port16     (region_port16),
        .waits      (region_waits),
        .idx        (hit_idx),
        .sel_port16 (hit_port16),
        .sel_waits  (hit_waits)
    );

    always_comb begin
        s_nxt    = s_r;
        s_nxt.done = 1'b0;
        s_nxt.cke  = 1'b1; // RQ15
        beat_end = 1'b0;
        bb_req   = (req_size == ebi_pkg::SIZE_BYTE) || !hit_port16;
        bb       = (s_r.size == ebi_pkg::SIZE_BYTE) || !s_r.wide;
        sd_cur   = (s_r.region == ebi_pkg::REG_SD0) || (s_r.region == ebi_pkg::REG_SD1);
        // Even byte sits on the upper lane; a narrow port always uses the upper lane
        lane8    = (s_r.wide && s_r.addr[0]) ? data_in[7:0] : data_in[15:8];
        unique case (req_size)
            ebi_pkg::SIZE_BYTE: nbytes = 3'h1;
            ebi_pkg::SIZE_WORD: nbytes = 3'h2;
            default:            nbytes = 3'h4;
        endcase

        unique case (s_r.st)
            ebi_pkg::ST_IDLE: begin
                if (req_valid) begin
                    s_nxt.wr     = req_write;
                    s_nxt.size   = req_size;
                    s_nxt.addr   = req_addr;
                    s_nxt.region = hit_idx;
                    s_nxt.wide   = hit_port16; // RQ5
                    s_nxt.waits  = hit_waits;
                    s_nxt.beats  = bb_req ? nbytes : (nbytes >> 1);
                    s_nxt.rsh    = '0;
                    // Left-justify so each beat takes the most significant part first
                    unique case (req_size)
                        ebi_pkg::SIZE_BYTE: s_nxt.wsh = {req_wdata[7:0], 24'h000000};
                        ebi_pkg::SIZE_WORD: s_nxt.wsh = {req_wdata[15:0], 16'h0000};
                        default:            s_nxt.wsh = req_wdata;
                    endcase
                    if ((hit_idx == ebi_pkg::REG_SD0) || (hit_idx == ebi_pkg::REG_SD1)) begin
                        s_nxt.st = ebi_pkg::ST_SD_ACT;
                    end else begin
                        s_nxt.st = ebi_pkg::ST_SETUP;
                    end
                end
            end
            ebi_pkg::ST_SETUP: begin
                s_nxt.cnt = s_r.waits;
                s_nxt.st  = ebi_pkg::ST_STROBE;
            end
            ebi_pkg::ST_STROBE: begin
                if (!transfer_ack_n) begin
                    beat_end = 1'b1; // RQ20
                end else if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else if (!isa_io_ready && ((s_r.region == ebi_pkg::REG_ISA0) ||
                                               (s_r.region == ebi_pkg::REG_ISA1))) begin
                    s_nxt.cnt = 4'h0; // RQ18
                end else begin
                    beat_end = 1'b1;
                end
            end
            ebi_pkg::ST_SD_ACT: begin
                s_nxt.cnt = ebi_pkg::SD_RCD_WAIT;
                s_nxt.st  = ebi_pkg::ST_SD_RCD;
            end
            ebi_pkg::ST_SD_RCD: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.st = ebi_pkg::ST_SD_CMD;
                end
            end
            ebi_pkg::ST_SD_CMD: begin
                if (s_r.wr) begin
                    beat_end = 1'b1;
                end else begin
                    s_nxt.cnt = ebi_pkg::SD_CL_WAIT;
                    s_nxt.st  = ebi_pkg::ST_SD_CL;
                end
            end
            ebi_pkg::ST_SD_CL: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    beat_end = 1'b1;
                end
            end
            ebi_pkg::ST_RECOVER: begin
                if (s_r.beats != 3'h0) begin
                    s_nxt.st = sd_cur ? ebi_pkg::ST_SD_ACT : ebi_pkg::ST_SETUP;
                end else begin
                    s_nxt.st   = ebi_pkg::ST_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
        endcase

        if (beat_end) begin
            if (!s_r.wr) begin
                s_nxt.rsh = bb ? {s_r.rsh[23:0], lane8} : {s_r.rsh[15:0], data_in}; // RQ4
            end
            s_nxt.wsh   = bb ? {s_r.wsh[23:0], 8'h00} : {s_r.wsh[15:0], 16'h0000};
            s_nxt.addr  = s_r.addr + (bb ? 26'h0000001 : 26'h0000002);
            s_nxt.beats = s_r.beats - 3'h1;
            s_nxt.st    = ebi_pkg::ST_RECOVER;
        end

        // Pin levels follow the state being entered, so every pin is a flop
        sd_nxt = (s_nxt.region == ebi_pkg::REG_SD0) || (s_nxt.region == ebi_pkg::REG_SD1);
        active = (s_nxt.st != ebi_pkg::ST_IDLE) && (s_nxt.st != ebi_pkg::ST_RECOVER);
        s_nxt.ready = (s_nxt.st == ebi_pkg::ST_IDLE);
        s_nxt.rw    = !(active && s_nxt.wr); // RQ1
        s_nxt.oe_n  = !(active && !s_nxt.wr && !sd_nxt); // RQ2
        for (int i = 0; i < 2; i++) begin
            s_nxt.mem_sel_n[i] = !((s_nxt.st == ebi_pkg::ST_STROBE) &&
                                   (s_nxt.region == ebi_pkg::REG_MEM0 + 3'(i))); // RQ16
            s_nxt.isa_rd_n[i]  = !((s_nxt.st == ebi_pkg::ST_STROBE) && !s_nxt.wr &&
                                   (s_nxt.region == ebi_pkg::REG_ISA0 + 3'(i))); // RQ17
            s_nxt.isa_wr_n[i]  = !((s_nxt.st == ebi_pkg::ST_STROBE) && s_nxt.wr &&
                                   (s_nxt.region == ebi_pkg::REG_ISA0 + 3'(i))); // RQ17
            s_nxt.sd_sel_n[i]  = !(((s_nxt.st == ebi_pkg::ST_SD_ACT) ||
                                    (s_nxt.st == ebi_pkg::ST_SD_CMD)) &&
                                   (s_nxt.region == ebi_pkg::REG_SD0 + 3'(i))); // RQ13
        end
        if (memsel1_as_gpo) begin
            s_nxt.mem_sel_n[1] = memsel1_gpo_val; // RQ16
        end
        if (sdsel1_as_gpo) begin
            s_nxt.sd_sel_n[1] = sdsel1_gpo_val; // RQ13
        end
        s_nxt.ras_n  = (s_nxt.st != ebi_pkg::ST_SD_ACT); // RQ11
        s_nxt.cas_n  = (s_nxt.st != ebi_pkg::ST_SD_CMD); // RQ11
        s_nxt.sdram_write_en_n_n = !((s_nxt.st == ebi_pkg::ST_SD_CMD) && s_nxt.wr); // RQ12
        // A byte beat hides the lane that holds the other byte of the halfword
        s_nxt.umask  = ((s_nxt.size == ebi_pkg::SIZE_BYTE) || !s_nxt.wide) && s_nxt.addr[0]; // RQ14
        s_nxt.lmask  = ((s_nxt.size == ebi_pkg::SIZE_BYTE) || !s_nxt.wide) && !s_nxt.addr[0]; // RQ14
        s_nxt.bufen[0] = active && ((s_nxt.region == ebi_pkg::REG_ISA0) ||
                                    (s_nxt.region == ebi_pkg::REG_ISA1)); // RQ21
        s_nxt.bufen[1] = active && ((s_nxt.region == ebi_pkg::REG_MEM0) ||
                                    (s_nxt.region == ebi_pkg::REG_MEM1) ||
                                    (s_nxt.region == ebi_pkg::REG_NONE)); // RQ21
        s_nxt.baddr = s_nxt.addr[23:1]; // RQ8
        if (sd_nxt) begin
            s_nxt.baddr = '0;
            s_nxt.baddr[ebi_pkg::PIN_BANK_LSB +: ebi_pkg::BANK_W] =
                s_nxt.addr[ebi_pkg::BANK_LSB +: ebi_pkg::BANK_W]; // RQ10
            if (s_nxt.st == ebi_pkg::ST_SD_CMD) begin
                s_nxt.baddr[ebi_pkg::PIN_COL_LSB +: ebi_pkg::COL_W] =
                    s_nxt.addr[ebi_pkg::COL_LSB +: ebi_pkg::COL_W]; // RQ8
                // Auto precharge keeps every access a closed-page access
                s_nxt.baddr[ebi_pkg::PIN_AUTOPRE] = 1'b1;
            end else begin
                s_nxt.baddr[ebi_pkg::PIN_ROW_LSB +: ebi_pkg::ROW_W] =
                    s_nxt.addr[ebi_pkg::ROW_LSB +: ebi_pkg::ROW_W]; // RQ8
            end
        end
        s_nxt.a25 = addr25_as_gpo ? addr25_gpo_val : s_nxt.addr[25]; // RQ9
        // Narrow data is copied to both lanes so all sixteen lines carry a value
        if ((s_nxt.size == ebi_pkg::SIZE_BYTE) || !s_nxt.wide) begin
            s_nxt.dout = {s_nxt.wsh[31:24], s_nxt.wsh[31:24]}; // RQ7
        end else begin
            s_nxt.dout = s_nxt.wsh[31:16]; // RQ7
        end
        s_nxt.doe = s_nxt.wr && ((s_nxt.st == ebi_pkg::ST_SETUP) ||
                                 (s_nxt.st == ebi_pkg::ST_STROBE) ||
                                 (s_nxt.st == ebi_pkg::ST_SD_CMD)); // RQ3
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= ebi_pkg::BUS_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready           = s_r.ready;
    assign rsp_done            = s_r.done;
    assign rsp_rdata           = s_r.rsh;
    assign bus_addr            = s_r.baddr;
    assign bus_addr25          = s_r.a25;
    assign bus_read_write      = s_r.rw;
    assign bus_output_en_n     = s_r.oe_n;
    assign data_out            = s_r.dout;
    assign data_oe             = s_r.doe;
    assign sdram_row_strobe_n  = s_r.ras_n;
    assign sdram_col_strobe_n  = s_r.cas_n;
    assign sdram_write_en_n    = s_r.sdram_write_en_n_n;
    assign sdram_select0_n     = s_r.sd_sel_n[0];
    assign sdram_select1_n     = s_r.sd_sel_n[1];
    assign sdram_upper_mask    = s_r.umask;
    assign sdram_lower_mask    = s_r.lmask;
    assign sdram_clock_enable  = s_r.cke;
    assign mem_select0_n       = s_r.mem_sel_n[0];
    assign mem_select1_n       = s_r.mem_sel_n[1];
    assign isa0_read_strobe_n  = s_r.isa_rd_n[0];
    assign isa0_write_strobe_n = s_r.isa_wr_n[0];
    assign isa1_read_strobe_n  = s_r.isa_rd_n[1];
    assign isa1_write_strobe_n = s_r.isa_wr_n[1];
    assign buffer_enable0      = s_r.bufen[0]; // RQ19
    assign buffer_enable1      = s_r.bufen[1];

endmodule : ext_bus_if

`default_nettype wire

// ===== hdl/ebi_pkg.sv
/*
 * Constants, state encoding and register layout of the external bus interface.
 * Assumes one 100 MHz clock (sys_clk) shared by the core side and the memory bus.
 */
package ebi_pkg;

    // Region decode: six programmable windows compared against addr[25:20]
    localparam int         NUM_REGIONS    = 6;
    localparam int         DECODE_BITS    = 6;
    localparam int         DECODE_LSB     = 20;
    localparam logic [2:0] REG_MEM0       = 3'h0;
    localparam logic [2:0] REG_MEM1       = 3'h1;
    localparam logic [2:0] REG_ISA0       = 3'h2;
    localparam logic [2:0] REG_ISA1       = 3'h3;
    localparam logic [2:0] REG_SD0        = 3'h4;
    localparam logic [2:0] REG_SD1        = 3'h5;
    localparam logic [2:0] REG_NONE       = 3'h7;

    // Fallback used when no window matches
    localparam logic       DEFAULT_PORT16 = 1'b1;
    localparam logic [3:0] DEFAULT_WAITS  = 4'h3;

    // Operand sizes
    localparam logic [1:0] SIZE_BYTE      = 2'h0;
    localparam logic [1:0] SIZE_WORD      = 2'h1;

    // Memory command timing, in sys_clk cycles
    localparam logic [3:0] SD_RCD_WAIT    = 4'h1;
    localparam logic [3:0] SD_CL_WAIT     = 4'h1;

    // Row/column multiplexing of the byte address onto the address pins
    localparam int         ROW_LSB        = 10;
    localparam int         ROW_W          = 13;
    localparam int         COL_LSB        = 1;
    localparam int         COL_W          = 9;
    localparam int         BANK_LSB       = 23;
    localparam int         BANK_W         = 2;
    localparam int         PIN_ROW_LSB    = 1;
    localparam int         PIN_COL_LSB    = 1;
    localparam int         PIN_BANK_LSB   = 14;
    localparam int         PIN_AUTOPRE    = 11;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_STROBE  = 3'b010,
        ST_SD_ACT  = 3'b011,
        ST_SD_RCD  = 3'b100,
        ST_SD_CMD  = 3'b101,
        ST_SD_CL   = 3'b110,
        ST_RECOVER = 3'b111
    } bus_state_t;

    typedef struct packed {
        bus_state_t  st;
        logic [3:0]  cnt;
        logic [3:0]  waits;
        logic [2:0]  region;
        logic        wide;
        logic        wr;
        logic [1:0]  size;
        logic [2:0]  beats;
        logic [25:0] addr;
        logic [31:0] wsh;
        logic [31:0] rsh;
        logic        ready;
        logic        done;
        logic        rw;
        logic        oe_n;
        logic [1:0]  mem_sel_n;
        logic [1:0]  isa_rd_n;
        logic [1:0]  isa_wr_n;
        logic        ras_n;
        logic        cas_n;
        logic        sdram_write_en_n_n;
        logic [1:0]  sd_sel_n;
        logic        umask;
        logic        lmask;
        logic        cke;
        logic [1:0]  bufen;
        logic [23:1] baddr;
        logic        a25;
        logic [15:0] dout;
        logic        doe;
    } bus_regs_t;

    localparam bus_regs_t BUS_RESET = '{
        st:        ST_IDLE,
        rw:        1'b1,
        oe_n:      1'b1,
        mem_sel_n: 2'h3,
        isa_rd_n:  2'h3,
        isa_wr_n:  2'h3,
        ras_n:     1'b1,
        cas_n:     1'b1,
        sdram_write_en_n_n:    1'b1,
        sd_sel_n:  2'h3,
        default:   '0
    };

endpackage : ebi_pkg

// ===== hdl/region_match.sv
/*
 * Address window decoder: finds the lowest numbered enabled window that
 * matches the upper address bits and returns its port width and wait count,
 * or the fixed fallback settings when nothing matches.
 * Purely combinational; the caller registers whatever it takes from here.
 */
`timescale 1ns/100ps
`default_nettype none

module region_match (
    // Address under decode
    input  wire logic [ebi_pkg::DECODE_BITS-1:0]                          addr_hi,
    // Window settings
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0]                          enable,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][ebi_pkg::DECODE_BITS-1:0] base,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][ebi_pkg::DECODE_BITS-1:0] mask,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0]                          port16,
    input  wire logic [ebi_pkg::NUM_REGIONS-1:0][3:0]                     waits,
    // Decode result
    output logic      [2:0]                                               idx,
    output logic                                                          sel_port16,
    output logic      [3:0]                                               sel_waits
);

    logic [ebi_pkg::NUM_REGIONS-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < ebi_pkg::NUM_REGIONS; g++) begin : g_win
            assign hit[g] = enable[g] && (((addr_hi ^ base[g]) & mask[g]) == '0);
        end
    endgenerate

    // Downward loop so the lowest window wins on overlap
    always_comb begin
        idx        = ebi_pkg::REG_NONE;
        sel_port16 = ebi_pkg::DEFAULT_PORT16; // RQ6
        sel_waits  = ebi_pkg::DEFAULT_WAITS;  // RQ6
        for (int i = ebi_pkg::NUM_REGIONS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                idx        = 3'(i);
                sel_port16 = port16[i]; // RQ5
                sel_waits  = waits[i];
            end
        end
    end

endmodule : region_match

`default_nettype wire

// ===== verif/ext_bus_if_props.sv
/* Pin-level checks of the external bus interface.
   Assumes one clock domain and binding to the top module. */
`timescale 1ns/100ps
`default_nettype none
module ext_bus_if_props (
    input wire logic sys_clk, nrst, req_ready, transfer_ack_n, isa_io_ready,
    input wire logic bus_read_write, bus_output_en_n, data_oe, sdram_clock_enable,
    input wire logic sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n,
    input wire logic mem_select0_n, isa0_read_strobe_n, buffer_enable0, buffer_enable1
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_wr_low; data_oe |-> !bus_read_write; endproperty
    property p_oe_rd; !bus_output_en_n |-> bus_read_write && !data_oe; endproperty
    property p_ras_cas; !sdram_row_strobe_n |-> ##3 (!sdram_col_strobe_n && sdram_row_strobe_n);
    endproperty
    property p_sdram_write_en_n; !sdram_write_en_n |-> !sdram_col_strobe_n && !bus_read_write && data_oe;
    endproperty
    property p_ack; !mem_select0_n && !transfer_ack_n |=> mem_select0_n; endproperty
    property p_stall; !isa0_read_strobe_n && !isa_io_ready && transfer_ack_n
        |=> !isa0_read_strobe_n; endproperty
    property p_isa_buf; !isa0_read_strobe_n |-> buffer_enable0 && !buffer_enable1; endproperty
    property p_mem_buf; !mem_select0_n |-> buffer_enable1 && !buffer_enable0; endproperty
    property p_idle; req_ready |-> !buffer_enable0 && !buffer_enable1 && bus_output_en_n;
    endproperty
    property p_cke; $past(nrst) |-> sdram_clock_enable; endproperty
    a_wr_low: assert property (p_wr_low) else $error("level high on write");
    a_oe_rd: assert property (p_oe_rd) else $error("enable outside read");
    a_ras_cas: assert property (p_ras_cas) else $error("row to column gap");
    a_sdram_write_en_n: assert property (p_sdram_write_en_n) else $error("write enable misplaced");
    a_ack: assert property (p_ack) else $error("ack did not end strobe");
    a_stall: assert property (p_stall) else $error("strobe ended early");
    a_isa_buf: assert property (p_isa_buf) else $error("wrong peripheral buffer");
    a_mem_buf: assert property (p_mem_buf) else $error("wrong buffer for memory");
    a_idle: assert property (p_idle) else $error("buffer on while idle");
    a_cke: assert property (p_cke) else $error("clock enable low");
    c_stall: cover property (!isa0_read_strobe_n && !isa_io_ready);
    c_row: cover property (!sdram_row_strobe_n);
    c_ack: cover property (!mem_select0_n && !transfer_ack_n);
endmodule : ext_bus_if_props
bind ext_bus_if ext_bus_if_props ext_bus_if_props_i (.*);
`default_nettype wire

// ===== verif/bus_partner.sv
/* Far-side model: memory or peripheral answering reads.
   Assumes stall is driven by the bench to hold the ready line low. */
`timescale 1ns/100ps
`default_nettype none
module bus_partner (
    input  wire logic        sys_clk,
    input  wire logic [23:1] bus_addr,
    input  wire logic        bus_output_en_n,
    input  wire logic        stall,
    output logic      [15:0] data_in,
    output logic             isa_io_ready
);
    logic [15:0] last_r = 16'h0000;
    always_ff @(posedge sys_clk) last_r <= data_in;
    // Released lines toggle so a late sample never reads as valid data
    assign data_in = !bus_output_en_n ? {bus_addr[8:1], ~bus_addr[8:1]} : ~last_r;
    assign isa_io_ready = !stall;
endmodule : bus_partner
`default_nettype wire

// ===== verif/ext_bus_if_tb.sv
/* Self-checking bench of the external bus interface.
   Assumes the partner answers with an address pattern. */
`timescale 1ns/100ps
`default_nettype none
module ext_bus_if_tb;
    logic sys_clk = 0, nrst = 0, req_valid = 0, req_write = 0, transfer_ack_n = 1, stall = 0;
    logic req_ready, rsp_done, isa_io_ready, data_oe, bus_addr25, bus_read_write;
    logic bus_output_en_n, sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n;
    logic sdram_select0_n, sdram_select1_n, sdram_upper_mask, sdram_lower_mask;
    logic sdram_clock_enable, mem_select0_n, mem_select1_n, isa0_read_strobe_n;
    logic isa0_write_strobe_n, isa1_read_strobe_n, isa1_write_strobe_n;
    logic buffer_enable0, buffer_enable1, addr25_as_gpo = 1, addr25_gpo_val = 1;
    logic sdsel1_as_gpo = 0, sdsel1_gpo_val = 0, memsel1_as_gpo = 0, memsel1_gpo_val = 0;
    logic [1:0] req_size = 0;
    logic [25:0] req_addr = 0;
    logic [31:0] req_wdata = 32'h1234ABCD, rsp_rdata, rd;
    logic [15:0] data_in, data_out;
    logic [23:1] bus_addr;
    logic [5:0] region_enable = 6'h15, region_port16 = 6'h3F;
    logic [5:0][5:0] region_base = {6'h0, 6'h2, 6'h0, 6'h1, 6'h0, 6'h0};
    logic [5:0][5:0] region_mask = {6{6'h3F}};
    logic [5:0][3:0] region_waits = {4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0};
    int err_total = 0, samples_checked = 0, n;
    ext_bus_if ext_bus_if_i (.*);
    bus_partner bus_partner_i (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [25:0] a);
        req_valid <= 1;
        req_write <= w;
        req_size <= sz;
        req_addr <= a;
        do @(posedge sys_clk); while (!req_ready);
        req_valid <= 0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (data_oe) rd = 32'(data_out);
        end while (!rsp_done);
        if (!w) rd = rsp_rdata;
    endtask : xfer
    task automatic wrap_up;
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic t_async;
        xfer(1, ebi_pkg::SIZE_BYTE, 26'h10);
        chk(32'(n), 32'h4);
        chk(rd, 32'hCDCD);
        xfer(0, ebi_pkg::SIZE_WORD, 26'h10);
        chk(rd, 32'h08F7);
    endtask : t_async
    task automatic t_unmatched;
        // Long read on the default 16-bit port splits into two beats, high half first
        xfer(0, 2'h2, 26'h3F00000);
        chk(rd, 32'h00FF01FE);
        chk(32'(n), 32'hD);
    endtask : t_unmatched
    task automatic t_isa;
        stall <= 1;
        fork
            xfer(0, ebi_pkg::SIZE_WORD, 26'h100004);
            begin
                repeat (9) @(posedge sys_clk);
                stall <= 0;
            end
        join
        chk(rd, 32'h02FD);
        chk(32'(n > 6), 32'h1);
    endtask : t_isa
    task automatic t_ack;
        region_waits[0] <= 4'hF;
        transfer_ack_n <= 0;
        xfer(0, ebi_pkg::SIZE_WORD, 26'h10);
        transfer_ack_n <= 1;
        chk(32'(n), 32'h4);
    endtask : t_ack
    task automatic t_sdram;
        xfer(1, ebi_pkg::SIZE_WORD, 26'h200010);
        chk(32'(n), 32'h6);
        xfer(0, ebi_pkg::SIZE_WORD, 26'h200010);
        chk(32'(n), 32'h8);
        chk(32'(bus_addr25), 32'h1);
    endtask : t_sdram
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1;
        @(posedge sys_clk);
        t_async();
        t_unmatched();
        t_isa();
        t_ack();
        t_sdram();
        wrap_up();
    end
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
endmodule : ext_bus_if_tb
`default_nettype wire
